// file: src/dsf_top.sv
`timescale 1ns/1ns
module dsf_top #(
    parameter int unsigned AW          = dsf_pkg::DSF_ADDR_W,
    parameter int unsigned DW          = dsf_pkg::DSF_DATA_W,
    parameter int unsigned INIT_CYC    = dsf_pkg::DSF_POWERUP_WAIT_CYC,
    parameter int unsigned LOCK_EDGES  = dsf_pkg::DSF_CLKGEN_LOCK_EDGES,
    parameter int unsigned STOP_CYC    = dsf_pkg::DSF_CLK_STOP_CYC,
    parameter int unsigned CAL_PERIOD  = dsf_pkg::DSF_CAL_PERIOD_CYC
) (
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  rst_i,
    input  wire logic                                  clk_true_i,
    input  wire logic                                  clk_comp_i,
    input  wire logic                                  read_sel_n_i,
    input  wire logic                                  write_sel_n_i,
    input  wire logic [AW-1:0]                         sync_addr_in_i,
    input  wire logic [DW-1:0]                         write_data_in_i,
    input  wire logic [DW/dsf_pkg::DSF_LANE_W-1:0]     byte_write_mask_n_i,
    input  wire logic                                  termination_enable_i,
    input  wire logic                                  clkgen_enable_i,
    input  wire logic                                  impedance_ref_up_i,
    input  wire logic                                  impedance_ref_dn_i,
    input  wire logic [dsf_pkg::DSF_AVS_AW-1:0]        avs_address_i,
    input  wire logic                                  avs_read_i,
    input  wire logic                                  avs_write_i,
    input  wire logic [31:0]                           avs_writedata_i,
    input  wire logic [3:0]                            avs_byteenable_i,
    output logic      [31:0]                           avs_readdata_o,
    output logic                                       avs_waitrequest_o,
    output logic      [DW-1:0]                         read_data_out_o,
    output logic                                       read_valid_out_o,
    output logic                                       echo_clock_out_o,
    output logic                                       echo_clock_out_n_o,
    output logic      [dsf_pkg::DSF_CODE_W-1:0]        drive_code_o,
    output logic      [dsf_pkg::DSF_CODE_W-1:0]        term_code_o,
    output logic                                       term_on_o
);
    import dsf_pkg::*;

    localparam int unsigned LANES = DW / DSF_LANE_W;
    localparam int unsigned SW    = 8 + AW + DW + LANES;
    localparam int unsigned ICW   = $clog2(INIT_CYC + 1);
    localparam int unsigned LCW   = $clog2(LOCK_EDGES + 1);
    localparam int unsigned SCW   = $clog2(STOP_CYC + 2);
    localparam int unsigned CCW   = $clog2(CAL_PERIOD + 1);

    // =========================================================================
    // pin synchronisers
    // =========================================================================
    // every pin passes two flops; the link clocks are sampled as plain levels
    logic [SW-1:0]     pin_raw;
    logic [SW-1:0]     sync1_q;
    logic [SW-1:0]     sync2_q;
    logic              k_s;
    logic              kb_s;
    logic              rd_n_s;
    logic              wr_n_s;
    logic              term_en_s;
    logic              doff_s;
    logic              up_s;
    logic              dn_s;
    logic [AW-1:0]     addr_s;
    logic [DW-1:0]     d_s;
    logic [LANES-1:0]  bw_s;
    logic              k_prev_q;
    logic              kb_prev_q;
    logic              k_rise;
    logic              kb_rise;

    assign pin_raw = {clk_true_i, clk_comp_i, read_sel_n_i, write_sel_n_i, termination_enable_i,
                      clkgen_enable_i, impedance_ref_up_i, impedance_ref_dn_i, sync_addr_in_i,
                      write_data_in_i, byte_write_mask_n_i};
    assign {k_s, kb_s, rd_n_s, wr_n_s, term_en_s, doff_s, up_s, dn_s, addr_s, d_s, bw_s} = sync2_q;
    assign k_rise  = k_s & ~k_prev_q;
    assign kb_rise = kb_s & ~kb_prev_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            k_prev_q  <= 1'h0;
            kb_prev_q <= 1'h0;
        end else begin
            sync1_q   <= pin_raw;
            sync2_q   <= sync1_q;
            k_prev_q  <= k_s;
            kb_prev_q <= kb_s;
        end
    end

    // =========================================================================
    // power-up wait, clock stop watch and clock generator lock
    // =========================================================================
    logic [SCW-1:0] idle_cnt_q;
    logic [ICW-1:0] init_cnt_q;
    logic           init_done_q;
    logic [LCW-1:0] lock_cnt_q;
    logic           clk_stop;
    logic           locked;
    logic           cmd_ok;

    assign clk_stop = idle_cnt_q > SCW'(STOP_CYC);
    assign locked   = lock_cnt_q == LCW'(LOCK_EDGES);
    // commands before the waits are over are dropped, not queued
    assign cmd_ok   = init_done_q & locked;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            idle_cnt_q <= '1;
        end else if (k_rise || kb_rise) begin
            idle_cnt_q <= '0;
        end else if (idle_cnt_q != '1) begin
            idle_cnt_q <= idle_cnt_q + SCW'(1);
        end
    end

    // the power-up wait is served once; a stop before it completes restarts it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            init_cnt_q  <= '0;
            init_done_q <= 1'h0;
        end else if (!init_done_q) begin
            if (clk_stop) begin
                init_cnt_q <= '0;
            end else if (init_cnt_q == ICW'(INIT_CYC - 1)) begin
                init_done_q <= 1'h1;
            end else begin
                init_cnt_q <= init_cnt_q + ICW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !doff_s || clk_stop) begin
            lock_cnt_q <= '0; // see RQ18, RQ19
        end else if (k_rise && !locked) begin
            lock_cnt_q <= lock_cnt_q + LCW'(1);
        end
    end

    // =========================================================================
    // write port and array
    // =========================================================================
    logic [2*DW-1:0]    mem_q [2**AW];
    logic               wr_pend_q;
    logic [DW-1:0]      wbeat0_q;
    logic [LANES-1:0]   wmask0_q;
    logic               wr_commit;
    logic [2*DW-1:0]    wdata_all;
    logic [2*LANES-1:0] wmask_all;

    assign wr_commit = kb_rise & wr_pend_q;
    assign wdata_all = {d_s, wbeat0_q};  // see RQ6, RQ9
    assign wmask_all = {bw_s, wmask0_q}; // see RQ7

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'h0;
            wbeat0_q  <= '0;
            wmask0_q  <= '1;
        end else if (k_rise) begin
            wr_pend_q <= cmd_ok & ~wr_n_s; // see RQ3, RQ4
            if (cmd_ok && !wr_n_s) begin
                wbeat0_q <= d_s;  // see RQ5
                wmask0_q <= bw_s; // see RQ7
            end
        end else if (kb_rise) begin
            wr_pend_q <= 1'h0;
        end
    end

    // lane l of the two-beat word holds data bits l*9 upward; mask bit l guards it
    always_ff @(posedge ref_clk_i) begin
        if (wr_commit) begin
            for (int l = 0; l < 2 * LANES; l++) begin
                if (!wmask_all[l]) begin
                    mem_q[addr_s][l*DSF_LANE_W +: DSF_LANE_W] <= wdata_all[l*DSF_LANE_W +: DSF_LANE_W]; // see RQ8 RQ10
                end
            end
        end
    end

    // =========================================================================
    // read port
    // =========================================================================
    // the array is read one true-clock edge after the command, which is after any
    // write taken on the same edge has committed, so reads see the newest data
    logic           rd_pend1_q;
    logic [AW-1:0]  rd_addr_q;
    logic           rd_pend2_q;
    logic [2*DW-1:0] rd_word_q;
    logic           beat1_pend_q;
    logic [DW-1:0]  rd_data_q;
    logic           read_valid_q;
    logic           echo_q;
    logic           echo_n_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_pend1_q   <= 1'h0;
            rd_addr_q    <= '0;
            rd_pend2_q   <= 1'h0;
            rd_word_q    <= '0;
            beat1_pend_q <= 1'h0;
            rd_data_q    <= '0;
            read_valid_q <= 1'h0;
        end else if (k_rise) begin
            rd_pend1_q   <= cmd_ok & ~rd_n_s; // see RQ1, RQ2
            rd_addr_q    <= addr_s;           // see RQ1
            rd_pend2_q   <= rd_pend1_q;
            if (rd_pend1_q) begin
                rd_word_q <= mem_q[rd_addr_q]; // see RQ21
            end
            beat1_pend_q <= rd_pend2_q;
            rd_data_q    <= rd_pend2_q ? rd_word_q[DW-1:0] : '0; // see RQ20
            read_valid_q <= rd_pend2_q;
        end else if (kb_rise && beat1_pend_q) begin
            beat1_pend_q <= 1'h0;
            rd_data_q    <= rd_word_q[2*DW-1:DW]; // see RQ20
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            echo_q   <= 1'h0;
            echo_n_q <= 1'h0;
        end else begin
            echo_q   <= k_s;  // see RQ20
            echo_n_q <= kb_s;
        end
    end

    // =========================================================================
    // impedance calibration and termination
    // =========================================================================
    logic [CCW-1:0]        cal_cnt_q;
    logic                  cal_tick;
    logic                  cal_en_q;
    logic [DSF_CODE_W-1:0] drv_code_q;
    logic [DSF_CODE_W-1:0] term_code_q;
    logic                  term_on_q;

    assign cal_tick = cal_cnt_q == CCW'(CAL_PERIOD - 1);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cal_cnt_q   <= '0;
            drv_code_q  <= DSF_CODE_RST;
            term_code_q <= DSF_CODE_RST;
            term_on_q   <= 1'h0;
        end else begin
            cal_cnt_q <= cal_tick ? '0 : cal_cnt_q + CCW'(1); // see RQ11
            if (cal_tick && cal_en_q) begin
                drv_code_q  <= dsf_step(drv_code_q, up_s, dn_s);  // see RQ12
                term_code_q <= dsf_step(term_code_q, up_s, dn_s); // see RQ14
            end
            term_on_q <= term_en_s; // see RQ13
        end
    end

    // =========================================================================
    // avalon-mm slave
    // =========================================================================
    // fixed one wait state keeps the master's timing trivially predictable
    logic        wait_q;
    logic [31:0] readdata_q;
    logic        bus_req;
    logic        bus_wr_done;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [31:0] codes_word;

    assign bus_req     = (avs_read_i | avs_write_i) & wait_q;
    assign bus_wr_done = avs_write_i & ~wait_q;
    assign status_word = 32'((init_done_q << DSF_STAT_INIT_BIT) | (locked << DSF_STAT_LOCK_BIT)
                         | (!clk_stop << DSF_STAT_CLKRUN_BIT) | (term_on_q << DSF_STAT_TERM_BIT));
    assign codes_word  = 32'((drv_code_q << DSF_CODES_DRV_POS) | (term_code_q << DSF_CODES_TERM_POS));
    assign rd_mux      = (avs_address_i == DSF_REG_CTRL)   ? 32'(cal_en_q << DSF_CTRL_CAL_EN_BIT) :
                         (avs_address_i == DSF_REG_STATUS) ? status_word :
                         (avs_address_i == DSF_REG_CODES)  ? codes_word : 32'h0;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wait_q     <= 1'h1;
            readdata_q <= '0;
            cal_en_q   <= DSF_CTRL_CAL_EN_RST;
        end else begin
            wait_q <= ~bus_req;
            if (bus_req && avs_read_i) begin
                readdata_q <= rd_mux;
            end
            if (bus_wr_done && avs_address_i == DSF_REG_CTRL && avs_byteenable_i[0]) begin
                cal_en_q <= avs_writedata_i[DSF_CTRL_CAL_EN_BIT];
            end
        end
    end

    assign avs_readdata_o     = readdata_q;
    assign avs_waitrequest_o  = wait_q;
    assign read_data_out_o    = rd_data_q;
    assign read_valid_out_o   = read_valid_q;
    assign echo_clock_out_o   = echo_q;
    assign echo_clock_out_n_o = echo_n_q;
    assign drive_code_o       = drv_code_q;
    assign term_code_o        = term_code_q;
    assign term_on_o          = term_on_q;

    // =========================================================================
    // assertions
    // =========================================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_rd_start;
        k_rise && cmd_ok && !rd_n_s |=> rd_pend1_q && rd_addr_q == $past(addr_s);
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read command not taken"); // see RQ1
    property p_rd_desel;
        k_rise && rd_n_s |=> !rd_pend1_q;
    endproperty
    a_rd_desel: assert property (p_rd_desel) else $error("deselect started a read"); // see RQ2
    property p_wr_start;
        k_rise && cmd_ok && !wr_n_s |=> wr_pend_q && wbeat0_q == $past(d_s) && wmask0_q == $past(bw_s);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write beat 0 not captured"); // see RQ5
    property p_wr_desel;
        k_rise && wr_n_s |=> !wr_pend_q;
    endproperty
    a_wr_desel: assert property (p_wr_desel) else $error("write deselect left a write pending"); // see RQ4
    property p_wr_commit;
        wr_pend_q && kb_rise |-> wr_commit ##1 !wr_pend_q;
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write not committed at comp edge"); // see RQ6
    property p_cal_restart;
        cal_tick |=> cal_cnt_q == '0 ##1 cal_cnt_q == CCW'(1);
    endproperty
    a_cal_restart: assert property (p_cal_restart) else $error("cal counter did not restart"); // see RQ11
    property p_code_step;
        !$stable(drv_code_q) |-> $past(cal_tick)
            && (drv_code_q == $past(drv_code_q) + 6'h01 || drv_code_q == $past(drv_code_q) - 6'h01);
    endproperty
    a_code_step: assert property (p_code_step) else $error("driver code moved more than a step"); // see RQ12
    property p_term;
        ##1 term_on_q == $past(term_en_s);
    endproperty
    a_term: assert property (p_term) else $error("termination does not follow enable"); // see RQ13
    property p_doff;
        !doff_s |=> !locked [*2];
    endproperty
    a_doff: assert property (p_doff) else $error("locked while generator disabled"); // see RQ19
    property p_stop;
        clk_stop |=> lock_cnt_q == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("lock kept across clock stop"); // see RQ18
    property p_rd_out;
        k_rise && rd_pend2_q |=> read_valid_q && rd_data_q == DW'($past(rd_word_q));
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("read beat 0 wrong or not valid"); // see RQ20

    c_wr_rd: cover property (wr_commit ##[1:40] (k_rise && rd_pend1_q));
    c_masked: cover property (wr_commit && wmask_all != '0 && wmask_all != '1);
    c_relock: cover property (locked ##1 !locked ##[1:1000] locked);
    c_step: cover property (cal_tick && cal_en_q && up_s && !dn_s);
endmodule : dsf_top

// file: src/dsf_pkg.sv
// Functional notes
// RQ1: read port samples read select and address on every true-clock rising edge.
// RQ2: read select low starts a read; high starts a read-port deselect.
// RQ3: write select sampled on true clock; write address on next complementary-clock rise.
// RQ4: write select low starts a write; high gives a write-port deselect.
// RQ5: first write data beat captured on the true-clock edge taking the command.
// RQ6: second write data beat captured on the complementary edge taking the address.
// RQ7: byte masks sampled with their data beat, separately for each beat.
// RQ8: a high mask keeps that byte unchanged in the array; mask 0 covers bits 0-8.
// RQ9: each accepted write stores two beats, 36 bits in all, at one address.
// RQ10: any 9-bit lane of either beat may be masked in any combination.
// RQ11: a cycle counter periodically triggers impedance evaluation, then restarts.
// RQ12: each evaluation moves the binary-weighted driver code at most one step.
// RQ13: termination enable high turns termination on; low or floating turns it off.
// RQ14: termination code is recalibrated by the same counter-triggered mechanism.
// RQ15: with termination on, controller drives data, masks and clocks to valid levels.
// RQ16: controller applies stable clocks 20 us after power-up before any command.
// RQ17: after clock generator enable rises, controller gives 2048 clocks before commands.
// RQ18: clocks stopped over 30 ns reset the clock generator; lock wait repeats.
// RQ19: clock generator enable low disables the generator; full lock wait needed again.
// RQ20: read data returns as two beats, true then complementary edge, with valid and echo.
// RQ21: read and write may share a cycle; reads return the newest written data.
package dsf_pkg;
    localparam int unsigned DSF_CLK_PERIOD_NS     = 8;
    localparam int unsigned DSF_POWERUP_WAIT_NS   = 20000;
    localparam int unsigned DSF_POWERUP_WAIT_CYC  =
        (DSF_POWERUP_WAIT_NS + DSF_CLK_PERIOD_NS - 1) / DSF_CLK_PERIOD_NS;
    localparam int unsigned DSF_CLKGEN_LOCK_EDGES = 2048;
    localparam int unsigned DSF_CLK_STOP_NS       = 30;
    localparam int unsigned DSF_CLK_STOP_CYC      = DSF_CLK_STOP_NS / DSF_CLK_PERIOD_NS;
    localparam int unsigned DSF_CAL_PERIOD_CYC    = 1024;
    localparam int unsigned DSF_ADDR_W            = 8;
    localparam int unsigned DSF_DATA_W            = 18;
    localparam int unsigned DSF_LANE_W            = 9;
    localparam int unsigned DSF_CODE_W            = 6;
    localparam logic [DSF_CODE_W-1:0] DSF_CODE_RST = 6'h20;
    localparam int unsigned DSF_AVS_AW            = 4;
    localparam logic [DSF_AVS_AW-1:0] DSF_REG_CTRL   = 4'h0;
    localparam logic [DSF_AVS_AW-1:0] DSF_REG_STATUS = 4'h4;
    localparam logic [DSF_AVS_AW-1:0] DSF_REG_CODES  = 4'h8;
    localparam int unsigned DSF_CTRL_CAL_EN_BIT   = 0;
    localparam logic        DSF_CTRL_CAL_EN_RST   = 1'h1;
    localparam int unsigned DSF_STAT_INIT_BIT     = 0;
    localparam int unsigned DSF_STAT_LOCK_BIT     = 1;
    localparam int unsigned DSF_STAT_CLKRUN_BIT   = 2;
    localparam int unsigned DSF_STAT_TERM_BIT     = 3;
    localparam int unsigned DSF_CODES_DRV_POS     = 0;
    localparam int unsigned DSF_CODES_TERM_POS    = 8;

    // one saturating step toward the comparator's verdict; conflicting verdicts hold
    function automatic logic [DSF_CODE_W-1:0] dsf_step(input logic [DSF_CODE_W-1:0] code,
                                                       input logic up,
                                                       input logic dn);
        logic [DSF_CODE_W-1:0] res;
        res = code;
        if (up && !dn && code != '1) begin
            res = code + 6'h01;
        end else if (dn && !up && code != '0) begin
            res = code - 6'h01;
        end
        return res;
    endfunction : dsf_step
endpackage : dsf_pkg

// file: tb/dsf_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================
// controller model: input clocks, commands and data
module dsf_ctrl_model
    import dsf_pkg::*;
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          run_i,
    output logic                               clk_true_o,
    output logic                               clk_comp_o,
    output logic                               read_sel_n_o,
    output logic                               write_sel_n_o,
    output logic [dsf_pkg::DSF_ADDR_W-1:0]     addr_o,
    output logic [dsf_pkg::DSF_DATA_W-1:0]     data_o,
    output logic [1:0]                         mask_o
);
    logic [2:0]              ph_q;
    logic                    req_q, rd_q, wr_q, wlive_q;
    logic [DSF_ADDR_W-1:0]   ra_q, wa_q;
    logic [DSF_DATA_W-1:0]   d0_q, d1_q;
    logic [1:0]              m0_q, m1_q;
    // eight ref cycles per true-clock period, complement mid-period; both stand low when stopped
    assign clk_true_o = run_i && (ph_q < 3'h4);
    assign clk_comp_o = run_i && (ph_q >= 3'h4);
    // lines always at a valid level, never floating
    initial begin
        ph_q = 3'h0;
        req_q = 1'b0;
        wlive_q = 1'b0;
        {read_sel_n_o, write_sel_n_o} = 2'b11;
        {addr_o, data_o, mask_o} = '0;
    end
    always @(posedge ref_clk_i) begin
        ph_q <= ph_q + 3'h1;
        if (ph_q == 3'h6) begin
            wlive_q <= req_q && wr_q;
            read_sel_n_o <= !(req_q && rd_q);
            write_sel_n_o <= !(req_q && wr_q);
            addr_o <= req_q ? ra_q : ~addr_o;
            data_o <= req_q ? d0_q : ~data_o;
            mask_o <= req_q ? m0_q : ~mask_o;
        end else if (ph_q == 3'h2) begin
            // released lines toggle so stale values cannot be mistaken for data
            {read_sel_n_o, write_sel_n_o} <= 2'b11;
            addr_o <= wlive_q ? wa_q : ~addr_o;
            data_o <= wlive_q ? d1_q : ~data_o;
            mask_o <= wlive_q ? m1_q : ~mask_o;
        end
    end
    task automatic cmd(input logic rd, input logic wr, input logic [7:0] ra, input logic [7:0] wa,
                       input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
        do @(posedge ref_clk_i); while (ph_q != 3'h5);
        {req_q, rd_q, wr_q, ra_q, wa_q} <= {1'b1, rd, wr, ra, wa};
        {d0_q, d1_q, m0_q, m1_q} <= {d0, d1, m0, m1};
        @(posedge ref_clk_i);
        req_q <= 1'b0;
    endtask : cmd
endmodule : dsf_ctrl_model

// file: tb/ddr_sram_port_frontend_tb_top.sv
`timescale 1ns/1ns
module ddr_sram_port_frontend_tb_top;
    import dsf_pkg::*;
    logic          ref_clk = 1'b0;
    logic          rst, run, term_en, gen_en, up, dn, av_rd, av_wr;
    logic [3:0]    av_addr;
    logic [31:0]   av_wd, av_rdata;
    logic          clk_t, clk_c, rsel_n, wsel_n, rvalid, wreq, term_on, echo, echo_n;
    logic [7:0]    addr;
    logic [17:0]   wdata, rdata;
    logic [1:0]    mask;
    logic [5:0]    drv, tcode;
    int            num_errors = 0;
    int            samples_checked = 0;
    always #4 ref_clk = ~ref_clk;
    dsf_ctrl_model ctl (.ref_clk_i(ref_clk), .run_i(run), .clk_true_o(clk_t), .clk_comp_o(clk_c),
        .read_sel_n_o(rsel_n), .write_sel_n_o(wsel_n), .addr_o(addr), .data_o(wdata), .mask_o(mask));
    dsf_top #(.INIT_CYC(20), .LOCK_EDGES(8), .CAL_PERIOD(16)) DUT (.ref_clk_i(ref_clk), .rst_i(rst),
        .clk_true_i(clk_t), .clk_comp_i(clk_c), .read_sel_n_i(rsel_n), .write_sel_n_i(wsel_n),
        .sync_addr_in_i(addr), .write_data_in_i(wdata), .byte_write_mask_n_i(mask),
        .termination_enable_i(term_en), .clkgen_enable_i(gen_en), .impedance_ref_up_i(up),
        .impedance_ref_dn_i(dn), .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wd), .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(wreq), .read_data_out_o(rdata), .read_valid_out_o(rvalid),
        .echo_clock_out_o(echo), .echo_clock_out_n_o(echo_n), .drive_code_o(drv), .term_code_o(tcode),
        .term_on_o(term_on));
    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        {av_addr, av_wr, av_rd, av_wd} <= {a, wr, !wr, wd};
        do @(posedge ref_clk); while (wreq !== 1'b0);
        rd = av_rdata;
        {av_wr, av_rd} <= 2'b00;
    endtask : av
    task automatic rd_chk(input logic [17:0] e0, input logic [17:0] e1);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rvalid !== 1'b1 && n < 80);
        chk(n < 80, 1'b1);
        @(posedge ref_clk);
        chk({rdata, rvalid, echo, echo_n}, {e0, 3'b110});
        repeat (4) @(posedge ref_clk);
        chk({rdata, rvalid, echo, echo_n}, {e1, 3'b101});
    endtask : rd_chk
    task automatic wait_ready;
        logic [31:0] r;
        int n;
        r = '0;
        n = 0;
        while (r[1:0] !== 2'b11 && n < 100) begin
            av(1'b0, DSF_REG_STATUS, 32'h0, r);
            n++;
        end
        chk(r[2:0], 3'h7);
    endtask : wait_ready
    // ==========================================
    // scenarios
    task automatic t_mem;
        logic [31:0] r;
        av(1'b0, 4'hC, 32'h0, r);
        chk(r, 32'h0);
        ctl.cmd(1'b0, 1'b1, 8'h00, 8'h5A, 18'h12345, 18'h2ABCD, 2'b00, 2'b00);
        ctl.cmd(1'b1, 1'b0, 8'h5A, 8'h00, 18'h0, 18'h0, 2'b00, 2'b00);
        rd_chk(18'h12345, 18'h2ABCD);
        // read in the write's own cycle must already see the merged lanes
        ctl.cmd(1'b1, 1'b1, 8'h5A, 8'h5A, 18'h3FFFF, 18'h00000, 2'b10, 2'b01);
        rd_chk({9'h091, 9'h1FF}, {9'h000, 9'h1CD});
        ctl.cmd(1'b1, 1'b1, 8'h5A, 8'h5A, 18'h00000, 18'h3FFFF, 2'b11, 2'b11);
        rd_chk({9'h091, 9'h1FF}, {9'h000, 9'h1CD});
    endtask : t_mem
    task automatic t_term;
        logic [31:0] r;
        term_en <= 1'b1;
        // two synchroniser flops plus the termination flop before status shows it
        repeat (4) @(posedge ref_clk);
        av(1'b0, DSF_REG_STATUS, 32'h0, r);
        chk({term_on, r[3]}, 2'b11);
        term_en <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(term_on, 1'b0);
    endtask : t_term
    task automatic t_cal;
        logic [31:0] r;
        logic [5:0] c;
        up <= 1'b1;
        repeat (36) @(posedge ref_clk);
        chk(drv >= 6'h21 && drv <= 6'h23, 1'b1);
        chk(tcode, drv);
        av(1'b1, DSF_REG_CTRL, 32'h0, r);
        // a tick on the disabling edge may still step the code
        @(posedge ref_clk);
        c = drv;
        repeat (40) @(posedge ref_clk);
        av(1'b0, DSF_REG_CODES, 32'h0, r);
        chk(r, {18'h0, c, 2'b00, c});
        {up, dn} <= 2'b01;
        av(1'b1, DSF_REG_CTRL, 32'h1, r);
        repeat (36) @(posedge ref_clk);
        chk(drv < c && drv + 6'h3 >= c, 1'b1);
        dn <= 1'b0;
    endtask : t_cal
    task automatic t_clk;
        logic [31:0] r;
        run <= 1'b0;
        repeat (10) @(posedge ref_clk);
        av(1'b0, DSF_REG_STATUS, 32'h0, r);
        chk(r[2:0], 3'h1);
        run <= 1'b1;
        wait_ready();
        gen_en <= 1'b0;
        // a write while the generator is off must be dropped
        ctl.cmd(1'b0, 1'b1, 8'h00, 8'h5A, 18'h0, 18'h0, 2'b00, 2'b00);
        av(1'b0, DSF_REG_STATUS, 32'h0, r);
        chk(r[1], 1'b0);
        gen_en <= 1'b1;
        wait_ready();
        ctl.cmd(1'b1, 1'b0, 8'h5A, 8'h00, 18'h0, 18'h0, 2'b00, 2'b00);
        rd_chk({9'h091, 9'h1FF}, {9'h000, 9'h1CD});
    endtask : t_clk
    task automatic results;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        {rst, run, gen_en, term_en, up, dn, av_rd, av_wr} = 8'hE0;
        av_addr = '0;
        av_wd = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk({wreq, rvalid, term_on, drv, tcode}, {3'b100, 6'h20, 6'h20});
        wait_ready();
        t_mem();
        t_term();
        t_cal();
        t_clk();
        results();
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule : ddr_sram_port_frontend_tb_top
